// *** rtl/awd_defines.vh ***
// Register offsets, field positions, reset values and timing counts of the watchdog.
`ifndef AWD_DEFINES_VH
`define AWD_DEFINES_VH
// ==========================================================================
// Register indexes; a register's byte address is four times its index.
// ==========================================================================
`define AWD_IDX_UNITS     8'hF1
`define AWD_IDX_VALUE     8'hF2
`define AWD_IDX_CONFIG    8'hF3
`define AWD_IDX_CONTROL   8'hF4
`define AWD_IDX_IRQ_STAT  8'hF5
`define AWD_IDX_IRQ_MASK  8'hF6
`define AWD_ADDR_W        12
// ==========================================================================
// Field positions.
// ==========================================================================
`define AWD_UNITS_SEC_BIT 7
`define AWD_CFG_GAME_BIT  0
`define AWD_CFG_KBD_BIT   1
`define AWD_CFG_MOUSE_BIT 2
`define AWD_CFG_MAP_HI    7
`define AWD_CFG_MAP_LO    4
`define AWD_CTL_STAT_BIT  0
`define AWD_CTL_FORCE_BIT 2
`define AWD_CTL_KBC_BIT   3
`define AWD_MAP_OFF       4'h0
`define AWD_MAP_IRQ1      4'h1
`define AWD_MAP_IRQ3      4'hF
`define AWD_RESET_VAL     8'h00
// ==========================================================================
// Timing: one second at 100 MHz, sixty seconds to the minute.
// ==========================================================================
`define AWD_CLK_HZ        100000000
`define AWD_SEC_PER_MIN   60
`define AWD_RESP_OKAY     2'b00
`define AWD_RESP_SLVERR   2'b10
`endif

// *** rtl/awd_watchdog.v ***
// Auxiliary watchdog timer with an AXI4-Lite register slave.
//
// Behaviour
// - Units register bit 7 picks count unit: zero minutes (default), one seconds.
// - A timeout value of zero keeps the watchdog disabled.
// - Nonzero timeout value counts that many selected units.
// - Game-port access restarts the count when config bit 0 is set.
// - Keyboard interrupt restarts the count when config bit 1 is set.
// - Mouse interrupt restarts the count when config bit 2 is set.
// - Config upper nibble routes interrupt: 0 off, 1 IRQ1, F IRQ3; 2 invalid.
// - Control bit 0 reads one after timeout, zero while counting; software writable.
// - Writing control bit 2 forces a timeout; the bit clears itself.
// - With control bit 3 set, kbc gate rising edge forces a timeout.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "awd_defines.vh"
module awd_watchdog #(
    parameter integer TICKS_PER_SEC = `AWD_CLK_HZ,
    parameter integer SEC_PER_MIN   = `AWD_SEC_PER_MIN
) (
    input  wire                    aclk,
    input  wire                    aresetn,
    input  wire [`AWD_ADDR_W-1:0]  s_axi_awaddr,
    input  wire                    s_axi_awvalid,
    output reg                     s_axi_awready,
    input  wire [31:0]             s_axi_wdata,
    input  wire [3:0]              s_axi_wstrb,
    input  wire                    s_axi_wvalid,
    output reg                     s_axi_wready,
    output reg  [1:0]              s_axi_bresp,
    output reg                     s_axi_bvalid,
    input  wire                    s_axi_bready,
    input  wire [`AWD_ADDR_W-1:0]  s_axi_araddr,
    input  wire                    s_axi_arvalid,
    output reg                     s_axi_arready,
    output reg  [31:0]             s_axi_rdata,
    output reg  [1:0]              s_axi_rresp,
    output reg                     s_axi_rvalid,
    input  wire                    s_axi_rready,
    input  wire                    game_port_access,
    input  wire                    kbd_irq_event,
    input  wire                    mouse_irq_event,
    input  wire                    kbc_gate_output,
    output reg                     irq1_ff,
    output reg                     irq3_ff,
    output reg                     irq_ff
);
// ==========================================================================
// Register byte addresses: each register sits on its own aligned word.
// ==========================================================================
localparam [`AWD_ADDR_W-1:0] ADDR_UNITS  = {2'b00, `AWD_IDX_UNITS, 2'b00};
localparam [`AWD_ADDR_W-1:0] ADDR_VALUE  = {2'b00, `AWD_IDX_VALUE, 2'b00};
localparam [`AWD_ADDR_W-1:0] ADDR_CONFIG = {2'b00, `AWD_IDX_CONFIG, 2'b00};
localparam [`AWD_ADDR_W-1:0] ADDR_CTRL   = {2'b00, `AWD_IDX_CONTROL, 2'b00};
localparam [`AWD_ADDR_W-1:0] ADDR_ISTAT  = {2'b00, `AWD_IDX_IRQ_STAT, 2'b00};
localparam [`AWD_ADDR_W-1:0] ADDR_IMASK  = {2'b00, `AWD_IDX_IRQ_MASK, 2'b00};

// ==========================================================================
// Registers.
// ==========================================================================
reg  [7:0]  units_ff;
reg  [7:0]  value_ff;
reg  [7:0]  config_ff;
reg         status_ff;
reg         force_ff;
reg         kbc_en_ff;
reg         kbc_dly_ff;
reg         istat_ff;
reg         imask_ff;
reg  [31:0] tick_ff;
reg  [5:0]  sub_ff;
reg  [7:0]  count_ff;
reg         aw_hold_ff;
reg         w_hold_ff;
reg  [`AWD_ADDR_W-1:0] awaddr_ff;
reg  [31:0] wdata_ff;
reg  [3:0]  wstrb_ff;

wire aw_fire = s_axi_awvalid & s_axi_awready;
wire w_fire  = s_axi_wvalid & s_axi_wready;
wire have_aw = aw_hold_ff | aw_fire;
wire have_w  = w_hold_ff | w_fire;
wire [`AWD_ADDR_W-1:0] waddr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
wire [31:0] wdat = w_hold_ff ? wdata_ff : s_axi_wdata;
wire        wlane0 = w_hold_ff ? wstrb_ff[0] : s_axi_wstrb[0];
wire do_wr = have_aw & have_w & ~s_axi_bvalid;
wire wr0   = do_wr & wlane0;
wire wr_units  = wr0 & (waddr == ADDR_UNITS);
wire wr_value  = wr0 & (waddr == ADDR_VALUE);
wire wr_config = wr0 & (waddr == ADDR_CONFIG);
wire wr_ctrl   = wr0 & (waddr == ADDR_CTRL);
wire wr_istat  = wr0 & (waddr == ADDR_ISTAT);
wire wr_imask  = wr0 & (waddr == ADDR_IMASK);
wire wr_mapped = wr_units | wr_value | wr_config | wr_ctrl | wr_istat | wr_imask;
wire addr_ok_w = (waddr >= ADDR_UNITS) & (waddr <= ADDR_IMASK);

// ==========================================================================
// Watchdog core.
// ==========================================================================
wire enabled   = (value_ff != 8'h00);
// The gate output may stay high indefinitely, so only its rising edge counts;
// the delay register resets low to match the idle level of the pin.
wire kbc_edge  = kbc_en_ff & kbc_gate_output & ~kbc_dly_ff;
wire forced    = force_ff | kbc_edge;
wire reload    = (config_ff[`AWD_CFG_GAME_BIT] & game_port_access)
               | (config_ff[`AWD_CFG_KBD_BIT] & kbd_irq_event)
               | (config_ff[`AWD_CFG_MOUSE_BIT] & mouse_irq_event)
               | wr_value;
wire sec_tick  = (tick_ff == TICKS_PER_SEC - 1);
wire unit_tick = sec_tick & (units_ff[`AWD_UNITS_SEC_BIT] |
                 (sub_ff == SEC_PER_MIN[5:0] - 6'd1));
// Expiry is blocked while status is set, so a stopped timer raises no second
// event until software or a reload clears it.
wire expire    = enabled & ~reload & ~status_ff & unit_tick & (count_ff == 8'h01);
wire timeout   = expire | forced;
wire [3:0] map = config_ff[`AWD_CFG_MAP_HI:`AWD_CFG_MAP_LO];

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        tick_ff    <= 32'h0000_0000;
        sub_ff     <= 6'h00;
        count_ff   <= 8'h00;
        status_ff  <= 1'b0;
        force_ff   <= 1'b0;
        kbc_en_ff  <= 1'b0;
        kbc_dly_ff <= 1'b0;
        istat_ff   <= 1'b0;
    end
    else
    begin
        kbc_dly_ff <= kbc_gate_output;
        // The sub-unit prescaler restarts on reload so a full unit always elapses.
        if (reload || !enabled || sec_tick)
            tick_ff <= 32'h0000_0000;
        else
            tick_ff <= tick_ff + 32'h0000_0001;
        if (reload || !enabled || unit_tick)
            sub_ff <= 6'h00;
        else if (sec_tick)
            sub_ff <= sub_ff + 6'h01;
        if (reload)
            count_ff <= wr_value ? wdat[7:0] : value_ff;
        else if (enabled && unit_tick && count_ff != 8'h00)
            count_ff <= count_ff - 8'h01;
        // A timeout in the same cycle as a software clear wins.
        if (timeout)
            status_ff <= 1'b1;
        else if (wr_ctrl)
            status_ff <= wdat[`AWD_CTL_STAT_BIT];
        else if (reload)
            status_ff <= 1'b0;
        // The force pulse lasts one cycle; the read path returns a constant zero for the control bit.
        force_ff <= wr_ctrl & wdat[`AWD_CTL_FORCE_BIT];
        if (wr_ctrl)
            kbc_en_ff <= wdat[`AWD_CTL_KBC_BIT];
        if (timeout)
            istat_ff <= 1'b1;
        else if (wr_istat && wdat[0])
            istat_ff <= 1'b0;
    end
end

// ==========================================================================
// Configuration registers and interrupt outputs.
// ==========================================================================
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        units_ff  <= `AWD_RESET_VAL;
        value_ff  <= `AWD_RESET_VAL;
        config_ff <= `AWD_RESET_VAL;
        imask_ff  <= 1'b0;
        irq1_ff   <= 1'b0;
        irq3_ff   <= 1'b0;
        irq_ff    <= 1'b0;
    end
    else
    begin
        // Only the units bit is stored; the reserved bits read as zero.
        if (wr_units)
            units_ff <= {wdat[`AWD_UNITS_SEC_BIT], 7'h00};
        if (wr_value)
            value_ff <= wdat[7:0];
        // Reserved bit 3 is not stored and reads as zero.
        if (wr_config)
            config_ff <= {wdat[7:4], 1'b0, wdat[2:0]};
        if (wr_imask)
            imask_ff <= wdat[0];
        // The invalid route code 2 and other unlisted codes drive no line.
        irq1_ff <= status_ff & (map == `AWD_MAP_IRQ1);
        irq3_ff <= status_ff & (map == `AWD_MAP_IRQ3);
        // The level interrupt follows the sticky status through the mask; clearing
        // the mask hides the event without losing it.
        irq_ff  <= istat_ff & imask_ff;
    end
end

// ==========================================================================
// AXI4-Lite write channel.
// ==========================================================================
// Address and data may arrive in either order; the first one is parked in a
// hold register until its partner arrives, so a split offer still completes.
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `AWD_RESP_OKAY;
        aw_hold_ff    <= 1'b0;
        w_hold_ff     <= 1'b0;
        awaddr_ff     <= {`AWD_ADDR_W{1'b0}};
        wdata_ff      <= 32'h0000_0000;
        wstrb_ff      <= 4'h0;
    end
    else
    begin
        s_axi_awready <= ~have_aw & ~s_axi_bvalid & ~s_axi_awready;
        s_axi_wready  <= ~have_w & ~s_axi_bvalid & ~s_axi_wready;
        if (aw_fire)
        begin
            awaddr_ff <= s_axi_awaddr;
        end
        if (w_fire)
        begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
        if (do_wr)
        begin
            aw_hold_ff    <= 1'b0;
            w_hold_ff     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= (addr_ok_w && (wr_mapped || !wlane0)) ?
                             `AWD_RESP_OKAY : `AWD_RESP_SLVERR;
        end
        else
        begin
            aw_hold_ff <= have_aw;
            w_hold_ff  <= have_w;
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
end

// ==========================================================================
// AXI4-Lite read channel.
// ==========================================================================
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= `AWD_RESP_OKAY;
    end
    else
    begin
        // Ready is offered on alternate idle cycles; a held request is taken at the
        // next offer, and no further read is taken until the answer is accepted.
        s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `AWD_RESP_OKAY;
            case (s_axi_araddr)
                ADDR_UNITS:  s_axi_rdata <= {24'h000000, units_ff};
                ADDR_VALUE:  s_axi_rdata <= {24'h000000, value_ff};
                ADDR_CONFIG: s_axi_rdata <= {24'h000000, config_ff};
                ADDR_CTRL:   s_axi_rdata <= {28'h0000000, kbc_en_ff, 2'b00, status_ff};
                ADDR_ISTAT:  s_axi_rdata <= {31'h00000000, istat_ff};
                ADDR_IMASK:  s_axi_rdata <= {31'h00000000, imask_ff};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `AWD_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule // awd_watchdog
`default_nettype wire

// *** test/awd_activity_src.sv ***
// Model of the activity sources: game port, keyboard and mouse events, gate output.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Activity source
// ==========================================================================
module awd_activity_src (
    input  wire logic       aclk,
    input  wire logic [2:0] req,
    input  wire logic       gate_req,
    output logic      [2:0] pulse,
    output logic            gate
);
    logic [2:0] req_ff = 3'h0;
    // Events are one-cycle pulses; a held request must not reload every cycle.
    always @(posedge aclk)
    begin
        req_ff <= req;
    end
    assign pulse = req & ~req_ff;
    assign gate  = gate_req;
endmodule // awd_activity_src
`default_nettype wire

// *** test/awd_checker_assertions.sv ***
// Bus handshake and interrupt routing assertions for the watchdog.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Checker
// ==========================================================================
module awd_checker (
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic s_axi_rvalid, s_axi_rready, irq1_ff, irq3_ff
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    AST_RD_ANSWER: assert property (s_rd_taken |=> s_axi_rvalid) else $error("read answer late");
    AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:4] s_axi_bvalid) else $error("no bvalid");
    AST_RV_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped");
    AST_BV_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answered twice");
    AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
    AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("awready early");
    AST_IRQ_ONE_LINE: assert property (!(irq1_ff && irq3_ff)) else $error("two irq lines");
endmodule // awd_checker
bind awd_watchdog awd_checker u_awd_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .irq1_ff, .irq3_ff);
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the auxiliary watchdog.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bench
// ==========================================================================
module tb_top;
    localparam int TPS = 10;
    localparam int SPM = 3;
    localparam logic [11:0] A_U = 12'h3C4, A_V = 12'h3C8, A_C = 12'h3CC;
    localparam logic [11:0] A_K = 12'h3D0, A_S = 12'h3D4, A_M = 12'h3D8;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, gate_req = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [2:0] req = 0, pulse;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, irq1, irq3, irq, gate;
    int bad_count = 0, n_compared = 0;
    always #5 aclk = ~aclk;
    awd_activity_src u_awd_activity_src (.aclk, .req, .gate_req, .pulse, .gate);
    awd_watchdog #(.TICKS_PER_SEC(TPS), .SEC_PER_MIN(SPM)) u_awd_watchdog (
        .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .game_port_access(pulse[0]),
        .kbd_irq_event(pulse[1]), .mouse_irq_event(pulse[2]), .kbc_gate_output(gate),
        .irq1_ff(irq1), .irq3_ff(irq3), .irq_ff(irq));
    task close_out;
        $display("errors %0d of %0d compared", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task give_up;
        chk(0, 1);
        close_out;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        int i;
        awaddr <= a; wdata <= {24'h0, d}; awv <= 1; wv <= 1; bready <= 1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge aclk);
            if (awv && awready) awv <= 0;
            if (wv && wready) wv <= 0;
            if (bvalid === 1) begin r = bresp; bready <= 0; break; end
        end
        if (i == 100) give_up;
        // One edge passes so that the next request does not reassign bready now.
        @(posedge aclk);
    endtask
    task w(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk(r, 2'h0);
    endtask
    task rd(input logic [11:0] a, output logic [33:0] v);
        int i;
        araddr <= a; arv <= 1; rready <= 1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge aclk);
            if (arv && arready) arv <= 0;
            if (rvalid === 1) begin v = {rresp, rdata}; rready <= 0; break; end
        end
        if (i == 100) give_up;
        @(posedge aclk);
    endtask
    task wait_hi(input int lim, output int n);
        for (n = 0; n < lim && irq1 !== 1 && irq3 !== 1; n++) @(posedge aclk);
    endtask
    task ev(input int k);
        req[k] <= 1;
        @(posedge aclk);
        req[k] <= 0;
        @(posedge aclk);
    endtask
    task sc_reset;
        logic [33:0] v;
        logic [1:0] r;
        for (int k = 0; k < 3; k++) begin rd(A_U + 4 * k, v); chk(v, 0); end
        rd(12'h010, v);
        chk(v, {2'h2, 32'h0});
        wr(12'h010, 8'h55, r);
        chk(r, 2'h2);
    endtask
    task sc_count;
        logic [33:0] v;
        int n;
        w(A_C, 8'h10); w(A_U, 8'h80); w(A_V, 8'h02); wait_hi(40, n);
        chk(n >= 8 && n <= 25 && irq1 === 1, 1);
        rd(A_K, v);
        chk(v, 34'h1);
        w(A_K, 8'h00); w(A_C, 8'hF0); w(A_U, 8'h00); w(A_V, 8'h01); wait_hi(60, n);
        chk(n >= 20 && n <= 38 && irq3 === 1 && irq1 === 0, 1);
    endtask
    task sc_disable;
        w(A_K, 8'h00); w(A_V, 8'h00);
        repeat (80) @(posedge aclk);
        chk(irq3, 0);
    endtask
    task sc_reload;
        int n;
        for (int k = 0; k < 3; k++)
        begin
            w(A_C, 8'h10 | (8'h01 << k)); w(A_U, 8'h80); w(A_K, 8'h00); w(A_V, 8'h02);
            repeat (8) begin repeat (6) @(posedge aclk); ev(k); end
            chk(irq1, 0);
            w(A_C, 8'h10);
            repeat (3) begin repeat (6) @(posedge aclk); ev(k); end
            wait_hi(20, n);
            chk(n < 20, 1);
        end
    endtask
    task sc_force;
        logic [33:0] v;
        int n;
        w(A_C, 8'hF0); w(A_V, 8'h00); w(A_K, 8'h00); w(A_S, 8'h01); w(A_M, 8'h01);
        repeat (2) @(posedge aclk);
        chk(irq, 0);
        w(A_K, 8'h04);
        wait_hi(10, n);
        chk(n < 10, 1);
        rd(A_K, v);
        chk(v, 34'h1);
        repeat (2) @(posedge aclk);
        chk(irq, 1);
        w(A_S, 8'h01);
        repeat (2) @(posedge aclk);
        chk(irq, 0);
        w(A_K, 8'h08);
        gate_req <= 1;
        wait_hi(10, n);
        chk(n < 10, 1);
        w(A_K, 8'h08);
        repeat (10) @(posedge aclk);
        chk(irq3, 0);
        gate_req <= 0;
        w(A_C, 8'h20); w(A_K, 8'h04);
        rd(A_K, v);
        chk(v, 34'h1);
        chk({irq1, irq3}, 2'b00);
        w(A_C, 8'h00);
        repeat (4) @(posedge aclk);
        chk({irq1, irq3}, 2'b00);
    endtask
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        sc_reset;
        sc_count;
        sc_disable;
        sc_reload;
        sc_force;
        close_out;
    end
endmodule // tb_top
`default_nettype wire
